// File: hw/ram_fifo_regs.svh
// register offsets, field positions and reset values of the ram fifo block
`ifndef RAM_FIFO_REGS_SVH
`define RAM_FIFO_REGS_SVH
`define OFS_CTRL 12'h000
`define OFS_THRESH 12'h004
`define OFS_STATUS 12'h008
`define OFS_LEVEL 12'h00C
`define OFS_LOAD_ADDR 12'h010
`define OFS_LOAD_DATA 12'h014
`define CTRL_RESET 32'h0000_0000
`define CTRL_WMODE_LSB 0
`define CTRL_RMODE_LSB 4
`define CTRL_FIFO_BIT 8
`define CTRL_DEPTH_LSB 16
`define THRESH_AE_LSB 0
`define THRESH_AF_LSB 16
`define THRESH_RESET 32'h0FF0_0010
`define DEPTH_RESET 13'h1000
`define TOTAL_BITS 4608
`define ADDR_W 13
`endif

// File: hw/ram_fifo_pkg.sv
// types shared by the ram fifo block
package ram_fifo_pkg;
    typedef enum logic [2:0] {
        org_x1 = 3'b000,
        org_x2 = 3'b001,
        org_x4 = 3'b010,
        org_x9 = 3'b011,
        org_x18 = 3'b100
    } org_t;
    typedef struct packed {
        logic en;
        logic [17:0] data;
    } wr_port_t;
    typedef struct packed {
        logic en;
    } rd_port_t;
    typedef struct packed {
        logic empty;
        logic full;
        logic near_empty_flag;
        logic near_full_flag;
    } fifo_flags_t;
endpackage

// File: hw/ram_fifo_block.sv
// embedded 4608-bit ram with per-port aspect ratio and fifo controller
// Summary of operation
// - storage is 4608 bits; x9 and x18 ports reach all of it, x1, x2 and x4 ports reach 4096 bits
// - each port is 256x18, 512x9, 1kx4, 2kx2 or 4kx1
// - read and write ports choose their widths independently
// - built-in controller runs the memory as a synchronous fifo
// - fifo depth and data width are programmable
// - empty, full and programmable near-empty and near-full flags
// - controller holds the read and write pointer counters
// - surrounding logic may combine blocks into wider or deeper ones
// - contents loadable through the test port for rom use
`timescale 1ns/1ns
`include "ram_fifo_regs.svh"
module ram_fifo_block (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ram_fifo_pkg::wr_port_t wr_port,
    input wire ram_fifo_pkg::rd_port_t rd_port,
    output ram_fifo_pkg::fifo_flags_t flags,
    output logic [17:0] rd_data,
    output logic rd_valid
);
    import ram_fifo_pkg::*;

    // bit-addressed array, 4608 cells, one aspect ratio view per port
    logic mem [0:`TOTAL_BITS-1];
    logic [31:0] ctrl;
    logic [31:0] thresh;
    logic [`ADDR_W-1:0] wptr;
    logic [`ADDR_W-1:0] rptr;
    logic [`ADDR_W:0] count;
    logic [`ADDR_W-1:0] load_addr;
    org_t wmode;
    org_t rmode;
    logic fifo_mode;
    logic [`ADDR_W-1:0] depth;
    logic [`ADDR_W-1:0] ae_lvl;
    logic [`ADDR_W-1:0] af_lvl;
    logic do_wr;
    logic do_rd;
    logic load_wr;
    logic [`ADDR_W:0] next_count;
    logic apb_wr;
    logic apb_rd;

    // bits per word for an organization; x9/x18 keep the parity bit
    function automatic logic [4:0] org_width(input org_t o);
        unique case (o)
            org_x1: org_width = 5'h01;
            org_x2: org_width = 5'h02;
            org_x4: org_width = 5'h04;
            org_x9: org_width = 5'h09;
            org_x18: org_width = 5'h12;
            default: org_width = 5'h01;
        endcase
    endfunction

    // word count of the block in an organization
    function automatic logic [`ADDR_W-1:0] org_words(input org_t o);
        unique case (o)
            org_x1: org_words = 13'h1000;
            org_x2: org_words = 13'h0800;
            org_x4: org_words = 13'h0400;
            org_x9: org_words = 13'h0200;
            org_x18: org_words = 13'h0100;
            default: org_words = 13'h1000;
        endcase
    endfunction

    // base bit of a word; x9 and x18 pack as 9-bit lanes in 4608 bits
    function automatic logic [`ADDR_W-1:0] bit_base(input org_t o,
            input logic [`ADDR_W-1:0] a);
        logic [`ADDR_W+4:0] p;
        p = 18'(a) * 18'(org_width(o));
        bit_base = p[`ADDR_W-1:0];
    endfunction

    // illegal codes fall back to x1
    function automatic org_t org_dec(input logic [2:0] c);
        org_dec = (c > 3'b100) ? org_x1 : org_t'(c);
    endfunction

    assign wmode = org_dec(ctrl[`CTRL_WMODE_LSB +: 3]);
    assign rmode = org_dec(ctrl[`CTRL_RMODE_LSB +: 3]);
    assign fifo_mode = ctrl[`CTRL_FIFO_BIT];
    assign depth = ctrl[`CTRL_DEPTH_LSB +: `ADDR_W];
    assign ae_lvl = thresh[`THRESH_AE_LSB +: `ADDR_W];
    assign af_lvl = thresh[`THRESH_AF_LSB +: `ADDR_W];

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && penable && !pwrite;
    assign load_wr = apb_wr && paddr == `OFS_LOAD_DATA;
    assign do_wr = wr_port.en && (!fifo_mode || !flags.full);
    assign do_rd = rd_port.en && (!fifo_mode || !flags.empty);
    assign next_count = count + (`ADDR_W+1)'(do_wr && fifo_mode)
        - (`ADDR_W+1)'(do_rd && fifo_mode);

    // register writes
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ctrl <= `CTRL_RESET | (32'(`DEPTH_RESET) << `CTRL_DEPTH_LSB);
            thresh <= `THRESH_RESET;
        end else if (apb_wr && paddr == `OFS_CTRL) begin
            ctrl <= pwdata;
        end else if (apb_wr && paddr == `OFS_THRESH) begin
            thresh <= pwdata;
        end
    end

    // test-port load path: address then data, address auto-increments
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            load_addr <= '0;
        end else if (apb_wr && paddr == `OFS_LOAD_ADDR) begin
            load_addr <= pwdata[`ADDR_W-1:0];
        end else if (load_wr) begin
            load_addr <= load_addr + 13'h0001;
        end
    end

    // pointers wrap at the programmed depth, capped by the org size
    always_ff @(posedge ref_clk) begin
        if (!rst_n || (apb_wr && paddr == `OFS_CTRL)) begin
            wptr <= '0;
            rptr <= '0;
            count <= '0;
        end else begin
            if (do_wr) begin
                wptr <= (wptr + 13'h0001 >= depth ||
                    wptr + 13'h0001 >= org_words(wmode)) ? '0 :
                    wptr + 13'h0001;
            end
            if (do_rd) begin
                rptr <= (rptr + 13'h0001 >= depth ||
                    rptr + 13'h0001 >= org_words(rmode)) ? '0 :
                    rptr + 13'h0001;
            end
            count <= next_count;
        end
    end

    // memory write: load path has priority over the user port
    always_ff @(posedge ref_clk) begin
        if (load_wr) begin
            mem[load_addr] <= pwdata[0];
        end else if (do_wr) begin
            for (int i = 0; i < 18; i++) begin
                if (5'(i) < org_width(wmode)) begin
                    mem[bit_base(wmode, wptr) + `ADDR_W'(i)] <=
                        wr_port.data[i];
                end
            end
        end
    end

    // memory read, registered
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_data <= '0;
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= do_rd;
            if (do_rd) begin
                for (int i = 0; i < 18; i++) begin
                    rd_data[i] <= (5'(i) < org_width(rmode)) ?
                        mem[bit_base(rmode, rptr) + `ADDR_W'(i)] :
                        1'b0;
                end
            end
        end
    end

    // flags from the next occupancy, so they are exact after each edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n || (apb_wr && paddr == `OFS_CTRL)) begin
            flags <= '{empty: 1'b1, full: 1'b0,
                near_empty_flag: 1'b1, near_full_flag: 1'b0};
        end else begin
            flags.empty <= next_count == '0;
            flags.full <= next_count >= (`ADDR_W+1)'(depth) ||
                next_count >= (`ADDR_W+1)'(org_words(wmode));
            flags.near_empty_flag <=
                next_count <= (`ADDR_W+1)'(ae_lvl);
            flags.near_full_flag <=
                next_count >= (`ADDR_W+1)'(af_lvl);
        end
    end

    // apb slave, one wait-free access; unmapped addresses error
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable) begin
                unique case (paddr)
                    `OFS_CTRL: prdata <= ctrl;
                    `OFS_THRESH: prdata <= thresh;
                    `OFS_STATUS: prdata <= 32'(flags);
                    `OFS_LEVEL: prdata <= 32'(count);
                    `OFS_LOAD_ADDR: prdata <= 32'(load_addr);
                    `OFS_LOAD_DATA: prdata <= 32'(mem[load_addr]);
                    default: begin
                        prdata <= '0;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule

// File: dv/ram_fifo_block_sva.sv
// assertions on the ram fifo block ports
`timescale 1ns/1ns
`include "ram_fifo_regs.svh"
module ram_fifo_block_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire ram_fifo_pkg::wr_port_t wr_port,
    input wire ram_fifo_pkg::rd_port_t rd_port,
    input wire ram_fifo_pkg::fifo_flags_t flags,
    input wire logic rd_valid
);
    import ram_fifo_pkg::*;
    logic ctrl_wr;
    logic fifo_on;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // mirror of the fifo enable bit: refusals exist only in fifo mode
    assign ctrl_wr = psel && penable && pwrite && paddr == `OFS_CTRL;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fifo_on <= 1'b0;
        end else if (ctrl_wr) begin
            fifo_on <= pwdata[`CTRL_FIFO_BIT];
        end
    end
    a_setup_ready: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_rd_refused: assert property (
        fifo_on && rd_port.en && flags.empty |=> !rd_valid)
        else $error("read served while empty");
    a_rd_served: assert property (
        rd_port.en && (!fifo_on || !flags.empty) |=> rd_valid)
        else $error("read not served");
    a_wr_fills: assert property (
        fifo_on && wr_port.en && !rd_port.en && !flags.full && !ctrl_wr
        |=> !flags.empty)
        else $error("empty kept after write");
    a_flag_excl: assert property (!(flags.full && flags.empty))
        else $error("full and empty together");
    a_empty_near: assert property (
        flags.empty |-> flags.near_empty_flag)
        else $error("empty without near empty");
    a_full_stays: assert property (
        flags.full && !rd_port.en && !psel |=> flags.full)
        else $error("full dropped without read");
    cover property (flags.full);
    cover property (fifo_on && rd_port.en && flags.empty);
    cover property (!fifo_on && rd_port.en && flags.empty);
    cover property (pslverr);
endmodule
bind ram_fifo_block ram_fifo_block_sva ram_fifo_block_sva_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .wr_port(wr_port),
    .rd_port(rd_port), .flags(flags), .rd_valid(rd_valid));

// File: dv/fifo_user_model.sv
// fabric user logic that drives the fifo ports
`timescale 1ns/1ns
module fifo_user_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic do_wr,
    input wire logic do_rd,
    input wire logic [17:0] wdata,
    output ram_fifo_pkg::wr_port_t wr_port,
    output ram_fifo_pkg::rd_port_t rd_port
);
    import ram_fifo_pkg::*;
    // idle data is inverted every idle cycle, so the stale word comes back on every second idle cycle
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wr_port <= '0;
            rd_port <= '0;
        end else begin
            wr_port.en <= do_wr;
            wr_port.data <= do_wr ? wdata : ~wr_port.data;
            rd_port.en <= do_rd;
        end
    end
endmodule

// File: dv/test_ram_fifo_block.sv
// self-checking bench for the ram fifo block
`timescale 1ns/1ns
`include "ram_fifo_regs.svh"
module test_ram_fifo_block;
    import ram_fifo_pkg::*;
    logic ref_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic do_wr = 0, do_rd = 0, pready, pslverr, rd_valid, e;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic [17:0] wdata = 0, rd_data;
    wr_port_t wr_port;
    rd_port_t rd_port;
    fifo_flags_t flags;
    int fails = 0, checks = 0;
    ram_fifo_block ram_fifo_block_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .wr_port(wr_port), .rd_port(rd_port),
        .flags(flags), .rd_data(rd_data), .rd_valid(rd_valid));
    fifo_user_model fifo_user_model_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .do_wr(do_wr), .do_rd(do_rd), .wdata(wdata), .wr_port(wr_port),
        .rd_port(rd_port));
    initial forever #2 ref_clk = ~ref_clk;
    task automatic final_report();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            final_report();
        end
        q = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic push(input logic [17:0] d);
        do_wr <= 1;
        wdata <= d;
        @(posedge ref_clk);
        do_wr <= 0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic pop(input logic [17:0] d, input logic ok);
        int n;
        logic v;
        v = 0;
        do_rd <= 1;
        @(posedge ref_clk);
        do_rd <= 0;
        for (n = 0; n < 6 && !v; n++) begin
            @(posedge ref_clk);
            v = (rd_valid === 1'b1);
        end
        check({31'h0, v}, {31'h0, ok});
        if (ok) check({14'h0, rd_data}, {14'h0, d});
        if (ok && !v) final_report();
    endtask
    task automatic sc_regs();
        apb(1'b0, `OFS_THRESH, 32'h0);
        check(q, 32'h0FF0_0010);
        apb(1'b0, `OFS_CTRL, 32'h0);
        check(q, 32'h1000_0000);
        check({31'h0, e}, 32'h0);
        apb(1'b0, `OFS_STATUS, 32'h0);
        check(q, 32'h0000_000A);
        apb(1'b1, 12'h020, 32'hFFFF_FFFF);
        check({31'h0, e}, 32'h1);
    endtask
    task automatic sc_fifo();
        apb(1'b1, `OFS_CTRL, 32'h0004_0144);
        apb(1'b1, `OFS_THRESH, 32'h0003_0001);
        push(18'h2_5A5A);
        check({28'h0, flags}, 32'h2);
        for (int i = 1; i < 4; i++) push(18'h1_0000 + 18'(i));
        check({28'h0, flags}, 32'h5);
        push(18'h3_FFFF);
        apb(1'b0, `OFS_LEVEL, 32'h0);
        check(q, 32'h4);
        pop(18'h2_5A5A, 1'b1);
        for (int i = 1; i < 4; i++) pop(18'h1_0000 + 18'(i), 1'b1);
        check({28'h0, flags}, 32'hA);
        pop(18'h0, 1'b0);
    endtask
    // ram mode, x4 write then x1 reads return the nibble bit by bit
    task automatic sc_ram();
        apb(1'b1, `OFS_CTRL, 32'h1000_0002);
        push(18'h0_000A);
        pop(18'h0, 1'b1);
        pop(18'h1, 1'b1);
        pop(18'h0, 1'b1);
        pop(18'h1, 1'b1);
    endtask
    task automatic sc_load();
        apb(1'b1, `OFS_LOAD_ADDR, 32'h5);
        apb(1'b1, `OFS_LOAD_DATA, 32'h1);
        apb(1'b0, `OFS_LOAD_ADDR, 32'h0);
        check(q, 32'h6);
        apb(1'b1, `OFS_LOAD_ADDR, 32'h5);
        apb(1'b0, `OFS_LOAD_DATA, 32'h0);
        check({31'h0, q[0]}, 32'h1);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst_n <= 1;
        sc_regs();
        sc_fifo();
        sc_ram();
        sc_load();
        final_report();
    end
endmodule
